// File: pkg/grc_pkg.sv
/*
  Constants, register map and field layout for the generator run controller.
  Assumes a 25 MHz ref_clk and battery voltage in 10 mV steps.
*/
`default_nettype none
package grc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned MINUTE_S    = 60;
  localparam int unsigned CYC_PER_MIN = CLK_HZ * MINUTE_S;
  localparam int unsigned MIN_PER_H   = 60;
  localparam int unsigned QUIET_FROM_H = 21;
  localparam int unsigned QUIET_TO_H   = 9;
  localparam logic [10:0] QUIET_START = 11'(QUIET_FROM_H * MIN_PER_H);
  localparam logic [10:0] QUIET_END   = 11'(QUIET_TO_H * MIN_PER_H);
  // ----------------------------------------
  // Modes
  // ----------------------------------------
  localparam logic [2:0] MODE_VQ  = 3'h0;
  localparam logic [2:0] MODE_SVQ = 3'h1;
  localparam logic [2:0] MODE_SQ  = 3'h2;
  localparam logic [2:0] MODE_MAN = 3'h3;
  localparam logic [2:0] MODE_V   = 3'h4;
  localparam logic [2:0] MODE_SV  = 3'h5;
  localparam logic [2:0] MODE_S   = 3'h6;
  // ----------------------------------------
  // Ranges and reset values
  // ----------------------------------------
  localparam logic [11:0] VON_MIN  = 12'h3e8;
  localparam logic [11:0] VON_MAX  = 12'h4e2;
  localparam logic [11:0] VOFF_MIN = 12'h44c;
  localparam logic [11:0] VOFF_MAX = 12'h672;
  localparam logic [6:0]  PON_MIN  = 7'h00;
  localparam logic [6:0]  PON_MAX  = 7'h63;
  localparam logic [6:0]  POFF_MIN = 7'h01;
  localparam logic [6:0]  POFF_MAX = 7'h64;
  localparam logic [3:0]  DLY_MIN  = 4'h1;
  localparam logic [3:0]  DLY_MAX  = 4'hf;
  localparam logic [5:0]  EXD_MIN  = 6'h02;
  localparam logic [5:0]  EXD_MAX  = 6'h3c;
  localparam logic [5:0]  DAY_SAT  = 6'h3f;
  localparam logic [7:0]  RUN_MAX  = 8'hf0;
  localparam logic [2:0]  RST_MODE = 3'h0;
  localparam logic [11:0] RST_VON  = 12'h47e;
  localparam logic [11:0] RST_VOFF = 12'h578;
  localparam logic [6:0]  RST_PON  = 7'h32;
  localparam logic [6:0]  RST_POFF = 7'h5a;
  localparam logic [3:0]  RST_DLY  = 4'ha;
  localparam logic [5:0]  RST_EXD  = 6'h0e;
  localparam logic [7:0]  RST_RUN  = 8'h3c;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] A_MODE   = 8'h00;
  localparam logic [7:0] A_VON    = 8'h04;
  localparam logic [7:0] A_PON    = 8'h08;
  localparam logic [7:0] A_VOFF   = 8'h0c;
  localparam logic [7:0] A_POFF   = 8'h10;
  localparam logic [7:0] A_DLY    = 8'h14;
  localparam logic [7:0] A_EXD    = 8'h18;
  localparam logic [7:0] A_RUN    = 8'h1c;
  localparam logic [7:0] A_DAYS   = 8'h20;
  localparam logic [7:0] A_ELAP   = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_CMD    = 8'h2c;
  localparam int unsigned B_RUN    = 0;
  localparam int unsigned B_EXER   = 1;
  localparam int unsigned B_QUIET  = 2;
  localparam int unsigned B_CONT   = 3;
  localparam int unsigned B_MAN    = 4;
  localparam int unsigned B_TOGGLE = 0;
  localparam int unsigned B_MSTART = 1;

  function automatic logic [11:0] clamp(logic [31:0] v, logic [11:0] lo, logic [11:0] hi);
    if (v < 32'(lo)) return lo;
    if (v > 32'(hi)) return hi;
    return v[11:0];
  endfunction : clamp
endpackage : grc_pkg
`default_nettype wire

// File: pkg/grc_dwell_if.sv
/*
  Carrier between the controller and a dwell qualifier.
  Assumes one owner drives the condition, delay and minute tick.
*/
`timescale 1ns/1ns
`default_nettype none
interface grc_dwell_if;
  logic       cond;
  logic [3:0] delay_min;
  logic       tick;
  logic       held;
  modport owner (output cond, output delay_min, output tick, input held);
  modport dwell (input cond, input delay_min, input tick, output held);
endinterface : grc_dwell_if
`default_nettype wire

// File: hw/grc_tick.sv
/*
  Free running minute prescaler.
  Assumes ref_clk at the package rate unless CYC is overridden.
*/
`timescale 1ns/1ns
`default_nettype none
module grc_tick #(
  parameter int unsigned CYC = grc_pkg::CYC_PER_MIN
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  output var  logic minute_tick
);
  logic [31:0] cnt_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r       <= '0;
      minute_tick <= 1'b0;
    end else if (cnt_r == 32'(CYC - 1)) begin
      cnt_r       <= '0;
      minute_tick <= 1'b1;
    end else begin
      cnt_r       <= cnt_r + 32'h1;
      minute_tick <= 1'b0;
    end
  end

  tick_period_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(minute_tick) |-> $past(cnt_r) == 32'(CYC - 1))
    else $error("minute tick off period");
endmodule : grc_tick
`default_nettype wire

// File: hw/grc_dwell.sv
/*
  Counts whole minutes a condition has held; restarts when it drops.
  Assumes a one-cycle minute tick. First minute may be partial.
*/
`timescale 1ns/1ns
`default_nettype none
module grc_dwell (
  input wire logic   ref_clk,
  input wire logic   reset_n,
  grc_dwell_if.dwell dw
);
  logic [3:0] cnt_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (!dw.cond) begin
      cnt_r <= '0;
    end else if (dw.tick && cnt_r != grc_pkg::DLY_MAX) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign dw.held = dw.cond && (cnt_r >= dw.delay_min);

  dwell_restart_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !dw.cond |=> cnt_r == '0 && (!dw.cond || !dw.held))
    else $error("dwell did not restart");
endmodule : grc_dwell
`default_nettype wire

// File: hw/grc_top.sv
/*
  Generator run controller: Avalon-MM register slave, mode decisions,
  exercise scheduling and the run contact.
  Assumes battery, charge, time-of-day and day tick inputs synchronous
  to ref_clk; battery voltage in 10 mV steps, time of day in minutes.
*/
// The Avalon-MM register port and the register addresses were left to the implementer.
// Functional notes
// - Modes 0,4: run after voltage low for delay, stop after high for delay.
// - Modes 1,5: run when charge falls to start level, stop on voltage dwell.
// - Modes 2,6: run when charge falls to start, stop when it rises.
// - Mode 3: start on manual command, run for run length, then stop.
// - Modes 0-2 block running from 9pm to 9am; modes 4-6 never.
// - Start voltage setting held, limited to 10 to 12.5 V.
// - Start charge setting held, limited to 0 to 99 percent.
// - Stop voltage setting held, limited to 11.0 to 16.5 V.
// - Stop charge setting held, limited to 1 to 100 percent.
// - Changeover delay in minutes, 1 to 15, qualifies voltage transitions.
// - Changeover delay starts at ten minutes.
// - Non-manual modes start an exercise each interval, 2 to 60 days.
// - Exercise lasts run length, 0 to 4 hours; elapsed time tracked.
// - Days since exercise and elapsed time are readable and writable.
// - No automatic exercise in manual mode.
// - Manual toggle ignored while exercising.
// - Toggle inverts run request; indicator shows wanted running.
// - Contact closed while run wanted outside the quiet window, open otherwise.
// - Generic program selection forces voltage mode 0.
`timescale 1ns/1ns
`default_nettype none
module grc_top #(
  parameter int unsigned CYC_PER_MIN = grc_pkg::CYC_PER_MIN
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic [11:0] batt_voltage,
  input  wire logic [6:0]  charge_pct,
  input  wire logic [10:0] time_of_day_min,
  input  wire logic        day_tick,
  input  wire logic        generic_program_sel,
  output var  logic        gen_contact,
  output var  logic        run_indicator
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0]  generator_mode_select_r, mode_w;
  logic [11:0] start_v_r, stop_v_r;
  logic [6:0]  start_pct_r, stop_pct_r;
  logic [3:0]  changeover_delay_r;
  logic [5:0]  exercise_interval_days_r, days_since_exercise_r;
  logic [7:0]  exercise_run_length_r, exercise_elapsed_time_r, man_min_r;
  logic [31:0] wd, rd_w;
  logic        run_req_r, exer_r, man_r, start_d_r, stop_d_r, minute_tick;
  logic        req_w, commit_w, man_mode_w, volt_start_w, pct_start_w, volt_stop_w;
  logic        pct_stop_w, quiet_w, start_lvl_w, stop_lvl_w, start_evt_w, stop_evt_w;
  logic        toggle_w, man_start_w, man_end_w, exer_start_w, exer_end_w, want_w;

  grc_dwell_if on_if ();
  grc_dwell_if off_if ();

  grc_tick #(
    .CYC (CYC_PER_MIN)
  ) u_tick (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .minute_tick (minute_tick)
  );

  grc_dwell u_on (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .dw      (on_if)
  );

  grc_dwell u_off (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .dw      (off_if)
  );

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // One wait state: request seen, then accepted on the next edge
  assign req_w    = avs_read || avs_write;
  assign commit_w = avs_write && !avs_waitrequest;
  assign wd       = avs_writedata;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req_w && avs_waitrequest);
    end
  end

  always_comb begin
    rd_w = '0;
    unique case (avs_address)
      grc_pkg::A_MODE:   rd_w = 32'(generator_mode_select_r);
      grc_pkg::A_VON:    rd_w = 32'(start_v_r);
      grc_pkg::A_PON:    rd_w = 32'(start_pct_r);
      grc_pkg::A_VOFF:   rd_w = 32'(stop_v_r);
      grc_pkg::A_POFF:   rd_w = 32'(stop_pct_r);
      grc_pkg::A_DLY:    rd_w = 32'(changeover_delay_r);
      grc_pkg::A_EXD:    rd_w = 32'(exercise_interval_days_r);
      grc_pkg::A_RUN:    rd_w = 32'(exercise_run_length_r);
      grc_pkg::A_DAYS:   rd_w = 32'(days_since_exercise_r);
      grc_pkg::A_ELAP:   rd_w = 32'(exercise_elapsed_time_r);
      grc_pkg::A_STATUS: begin
        rd_w[grc_pkg::B_RUN]   = run_req_r;
        rd_w[grc_pkg::B_EXER]  = exer_r;
        rd_w[grc_pkg::B_QUIET] = quiet_w;
        rd_w[grc_pkg::B_CONT]  = gen_contact;
        rd_w[grc_pkg::B_MAN]   = man_r;
      end
      default:           rd_w = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
    end else if (req_w && avs_waitrequest) begin
      avs_readdata <= rd_w;
    end
  end

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  // Out-of-range writes are clamped, except mode writes above 6, which are ignored
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      generator_mode_select_r  <= grc_pkg::RST_MODE;
      start_v_r                <= grc_pkg::RST_VON;
      start_pct_r              <= grc_pkg::RST_PON;
      stop_v_r                 <= grc_pkg::RST_VOFF;
      stop_pct_r               <= grc_pkg::RST_POFF;
      changeover_delay_r       <= grc_pkg::RST_DLY;
      exercise_interval_days_r <= grc_pkg::RST_EXD;
      exercise_run_length_r    <= grc_pkg::RST_RUN;
    end else if (commit_w) begin
      unique case (avs_address)
        grc_pkg::A_MODE: begin
          if (wd <= 32'(grc_pkg::MODE_S)) generator_mode_select_r <= wd[2:0];
        end
        grc_pkg::A_VON:  start_v_r <= grc_pkg::clamp(wd, grc_pkg::VON_MIN, grc_pkg::VON_MAX);
        grc_pkg::A_PON:  start_pct_r <= 7'(grc_pkg::clamp(wd, 12'(grc_pkg::PON_MIN),
                                            12'(grc_pkg::PON_MAX)));
        grc_pkg::A_VOFF: stop_v_r <= grc_pkg::clamp(wd, grc_pkg::VOFF_MIN,
                                      grc_pkg::VOFF_MAX);
        grc_pkg::A_POFF: stop_pct_r <= 7'(grc_pkg::clamp(wd, 12'(grc_pkg::POFF_MIN),
                                          12'(grc_pkg::POFF_MAX)));
        grc_pkg::A_DLY:  changeover_delay_r <= 4'(grc_pkg::clamp(wd, 12'(grc_pkg::DLY_MIN),
                                                  12'(grc_pkg::DLY_MAX)));
        grc_pkg::A_EXD:  exercise_interval_days_r <= 6'(grc_pkg::clamp(wd,
                           12'(grc_pkg::EXD_MIN), 12'(grc_pkg::EXD_MAX)));
        grc_pkg::A_RUN:  exercise_run_length_r <= 8'(grc_pkg::clamp(wd, '0,
                           12'(grc_pkg::RUN_MAX)));
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Mode decode and trigger conditions
  // ----------------------------------------
  assign mode_w = generic_program_sel ? grc_pkg::MODE_VQ : generator_mode_select_r;
  assign man_mode_w   = (mode_w == grc_pkg::MODE_MAN);
  assign volt_start_w = (mode_w == grc_pkg::MODE_VQ) || (mode_w == grc_pkg::MODE_V);
  assign pct_start_w  = (mode_w == grc_pkg::MODE_SVQ) || (mode_w == grc_pkg::MODE_SQ) ||
                        (mode_w == grc_pkg::MODE_SV) || (mode_w == grc_pkg::MODE_S);
  assign volt_stop_w  = (mode_w == grc_pkg::MODE_VQ) || (mode_w == grc_pkg::MODE_SVQ) ||
                        (mode_w == grc_pkg::MODE_V) || (mode_w == grc_pkg::MODE_SV);
  assign pct_stop_w   = (mode_w == grc_pkg::MODE_SQ) || (mode_w == grc_pkg::MODE_S);
  assign quiet_w      = (mode_w < grc_pkg::MODE_MAN) &&
                        (time_of_day_min >= grc_pkg::QUIET_START ||
                         time_of_day_min < grc_pkg::QUIET_END);

  assign on_if.cond       = volt_start_w && (batt_voltage <= start_v_r);
  assign on_if.delay_min  = changeover_delay_r;
  assign on_if.tick       = minute_tick;
  assign off_if.cond      = volt_stop_w && (batt_voltage >= stop_v_r);
  assign off_if.delay_min = changeover_delay_r;
  assign off_if.tick      = minute_tick;

  assign start_lvl_w = volt_start_w ? on_if.held :
                       (pct_start_w && charge_pct <= start_pct_r);
  assign stop_lvl_w  = volt_stop_w ? off_if.held :
                       (pct_stop_w && charge_pct >= stop_pct_r);

  // Edges, so a manual toggle is not overridden by a standing level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_d_r <= 1'b0;
      stop_d_r  <= 1'b0;
    end else begin
      start_d_r <= start_lvl_w;
      stop_d_r  <= stop_lvl_w;
    end
  end

  assign start_evt_w  = start_lvl_w && !start_d_r;
  assign stop_evt_w   = stop_lvl_w && !stop_d_r;
  assign toggle_w     = commit_w && avs_address == grc_pkg::A_CMD && wd[grc_pkg::B_TOGGLE];
  assign man_start_w  = commit_w && avs_address == grc_pkg::A_CMD &&
                        wd[grc_pkg::B_MSTART] && man_mode_w;
  assign man_end_w    = man_r && (man_min_r >= exercise_run_length_r);
  assign exer_start_w = !man_mode_w && !exer_r &&
                        (days_since_exercise_r >= exercise_interval_days_r);
  assign exer_end_w   = exer_r && (exercise_elapsed_time_r >= exercise_run_length_r);

  // ----------------------------------------
  // Run request
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_req_r <= 1'b0;
    end else if (man_end_w || stop_evt_w) begin
      run_req_r <= 1'b0;
    end else if (start_evt_w || man_start_w) begin
      run_req_r <= 1'b1;
    end else if (toggle_w && !exer_r) begin
      run_req_r <= !run_req_r;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      man_r     <= 1'b0;
      man_min_r <= '0;
    end else if (man_end_w || !man_mode_w) begin
      man_r     <= 1'b0;
    end else if (man_start_w) begin
      man_r     <= 1'b1;
      man_min_r <= '0;
    end else if (man_r && minute_tick && man_min_r != grc_pkg::RUN_MAX) begin
      man_min_r <= man_min_r + 8'h1;
    end
  end

  // ----------------------------------------
  // Exercise
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      exer_r <= 1'b0;
    end else if (exer_start_w) begin
      exer_r <= 1'b1;
    end else if (exer_end_w || man_mode_w) begin
      exer_r <= 1'b0;
    end
  end

  // Software writes win over the day tick in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      days_since_exercise_r <= '0;
    end else if (commit_w && avs_address == grc_pkg::A_DAYS) begin
      days_since_exercise_r <= 6'(grc_pkg::clamp(wd, '0, 12'(grc_pkg::EXD_MAX)));
    end else if (exer_start_w) begin
      days_since_exercise_r <= '0;
    end else if (day_tick && days_since_exercise_r != grc_pkg::DAY_SAT) begin
      days_since_exercise_r <= days_since_exercise_r + 6'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      exercise_elapsed_time_r <= '0;
    end else if (commit_w && avs_address == grc_pkg::A_ELAP) begin
      exercise_elapsed_time_r <= 8'(grc_pkg::clamp(wd, '0, 12'(grc_pkg::RUN_MAX)));
    end else if (exer_start_w) begin
      exercise_elapsed_time_r <= '0;
    end else if (exer_r && minute_tick && exercise_elapsed_time_r != grc_pkg::RUN_MAX) begin
      exercise_elapsed_time_r <= exercise_elapsed_time_r + 8'h1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign want_w = run_req_r || exer_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_contact   <= 1'b0;
      run_indicator <= 1'b0;
    end else begin
      gen_contact   <= want_w && !quiet_w;
      run_indicator <= want_w;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  quiet_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    quiet_w |=> !gen_contact) else $error("contact closed in quiet time");
  contact_follow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    want_w && !quiet_w |=> gen_contact) else $error("contact not closed");
  start_event_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    start_evt_w && !stop_evt_w && !man_end_w |=> run_req_r) else $error("start missed");
  toggle_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    exer_r && toggle_w && !start_evt_w && !stop_evt_w && !man_end_w && !man_start_w
    |=> $stable(run_req_r)) else $error("toggle acted during exercise");
  toggle_flip_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !exer_r && toggle_w && !start_evt_w && !stop_evt_w && !man_end_w && !man_start_w
    |=> run_req_r != $past(run_req_r)) else $error("toggle did not invert");
  manual_exer_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(exer_r) |-> $past(mode_w) != grc_pkg::MODE_MAN) else $error("exercise in manual");
  generic_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    generic_program_sel |-> mode_w == grc_pkg::MODE_VQ) else $error("generic mode not 0");
  exer_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    exer_start_w && !commit_w |=> exer_r && days_since_exercise_r == '0)
    else $error("exercise start wrong");
  man_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    man_end_w |=> !run_req_r && !man_r) else $error("manual run overran");
  von_range_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    start_v_r >= grc_pkg::VON_MIN && start_v_r <= grc_pkg::VON_MAX)
    else $error("start voltage out of range");
endmodule : grc_top
`default_nettype wire

// File: testbench/grc_gen_model.sv
/*
  Behavioural remote start unit seen through the run contact.
  Assumes the contact is synchronous to ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module grc_gen_model (
  input  wire logic ref_clk,
  input  wire logic contact,
  output var  logic running
);
  // Engine follows the contact one cycle late; failed starts not modelled
  always_ff @(posedge ref_clk) begin
    running <= contact;
  end
endmodule : grc_gen_model
`default_nettype wire

// File: testbench/generator_run_control_tb.sv
/*
  Self-checking bench for grc_top: bus tasks, scenarios, verdict.
  Assumes a four-cycle minute so that dwell waits stay short.
*/
`timescale 1ns/1ns
`default_nettype none
module generator_run_control_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [11:0] volt = 12'h514;
  logic [6:0]  chg = 7'h64;
  logic [10:0] tod = 11'h2d0;
  logic        gsel = 1'b0;
  logic        dtick = 1'b0;
  logic        contact;
  logic        ind;
  logic        running;
  logic [31:0] q;
  int          fails = 0;
  int          cmp_count = 0;

  always #20 ref_clk = ~ref_clk;

  grc_top #(.CYC_PER_MIN(4)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .batt_voltage(volt), .charge_pct(chg), .time_of_day_min(tod),
    .day_tick(dtick), .generic_program_sel(gsel), .gen_contact(contact), .run_indicator(ind));
  grc_gen_model gen_u (.ref_clk(ref_clk), .contact(contact), .running(running));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Held until waitrequest is sampled low at a rising edge; data taken and released there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic expect_contact(input logic exp, input int lim);
    int n;
    n = 0;
    while (contact !== exp && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    check({31'h0, contact}, {31'h0, exp});
  endtask : expect_contact

  task automatic t_regs;
    bus(1'b0, grc_pkg::A_DLY, 32'h0);
    check(q, 32'(grc_pkg::RST_DLY));
    bus(1'b0, 8'h3c, 32'h0);
    check(q, 32'h0);
    bus(1'b1, grc_pkg::A_VON, 32'h0);
    bus(1'b0, grc_pkg::A_VON, 32'h0);
    check(q, 32'(grc_pkg::VON_MIN));
    bus(1'b1, grc_pkg::A_POFF, 32'h0);
    bus(1'b0, grc_pkg::A_POFF, 32'h0);
    check(q, 32'(grc_pkg::POFF_MIN));
    bus(1'b1, grc_pkg::A_POFF, 32'h5a);
    $display("test regs done");
  endtask : t_regs

  task automatic t_charge;
    bus(1'b1, grc_pkg::A_MODE, 32'(grc_pkg::MODE_S));
    @(posedge ref_clk);
    chg <= 7'h32;
    expect_contact(1'b1, 10);
    @(negedge ref_clk);
    check({31'h0, running}, 32'h1);
    @(posedge ref_clk);
    chg <= 7'h5a;
    expect_contact(1'b0, 10);
    $display("test charge done");
  endtask : t_charge

  task automatic t_quiet;
    bus(1'b1, grc_pkg::A_MODE, 32'(grc_pkg::MODE_SQ));
    @(posedge ref_clk);
    tod <= 11'h528;
    chg <= 7'h64;
    repeat (3) @(posedge ref_clk);
    chg <= 7'h32;
    repeat (6) @(negedge ref_clk);
    check({31'h0, ind}, 32'h1);
    check({31'h0, contact}, 32'h0);
    @(posedge ref_clk);
    tod <= 11'h258;
    expect_contact(1'b1, 10);
    @(posedge ref_clk);
    chg <= 7'h5a;
    expect_contact(1'b0, 10);
    $display("test quiet done");
  endtask : t_quiet

  // Mode register says charge control, but the generic override wins
  task automatic t_generic;
    bus(1'b1, grc_pkg::A_MODE, 32'(grc_pkg::MODE_S));
    bus(1'b1, grc_pkg::A_DLY, 32'h1);
    @(posedge ref_clk);
    gsel <= 1'b1;
    volt <= 12'h3e8;
    expect_contact(1'b1, 20);
    @(posedge ref_clk);
    volt <= 12'h5dc;
    expect_contact(1'b0, 20);
    $display("test generic done");
  endtask : t_generic

  // Eight-minute exercise from a day tick; toggle ignored during it, honoured after
  task automatic t_exercise;
    bus(1'b1, grc_pkg::A_RUN, 32'h8);
    bus(1'b1, grc_pkg::A_DAYS, 32'hd);
    bus(1'b0, grc_pkg::A_DAYS, 32'h0);
    check(q, 32'hd);
    @(posedge ref_clk);
    dtick <= 1'b1;
    @(posedge ref_clk);
    dtick <= 1'b0;
    expect_contact(1'b1, 10);
    bus(1'b1, grc_pkg::A_CMD, 32'h1);
    bus(1'b0, grc_pkg::A_STATUS, 32'h0);
    check(q, 32'ha);
    expect_contact(1'b0, 40);
    bus(1'b0, grc_pkg::A_ELAP, 32'h0);
    check(q, 32'h8);
    bus(1'b0, grc_pkg::A_DAYS, 32'h0);
    check(q, 32'h0);
    bus(1'b1, grc_pkg::A_CMD, 32'h1);
    expect_contact(1'b1, 10);
    bus(1'b1, grc_pkg::A_CMD, 32'h1);
    expect_contact(1'b0, 10);
    $display("test exercise done");
  endtask : t_exercise

  task automatic t_manual;
    bus(1'b1, grc_pkg::A_MODE, 32'(grc_pkg::MODE_MAN));
    @(posedge ref_clk);
    gsel <= 1'b0;
    bus(1'b1, grc_pkg::A_DAYS, 32'he);
    bus(1'b0, grc_pkg::A_STATUS, 32'h0);
    check(q, 32'h0);
    bus(1'b1, grc_pkg::A_CMD, 32'h2);
    expect_contact(1'b1, 10);
    repeat (20) @(negedge ref_clk);
    check({31'h0, contact}, 32'h1);
    expect_contact(1'b0, 20);
    bus(1'b1, grc_pkg::A_DAYS, 32'h0);
    $display("test manual done");
  endtask : t_manual

  // Charge start, voltage stop, and no quiet window at 22:00
  task automatic t_socv;
    bus(1'b1, grc_pkg::A_MODE, 32'(grc_pkg::MODE_SV));
    @(posedge ref_clk);
    tod <= 11'h528;
    volt <= 12'h514;
    chg <= 7'h32;
    expect_contact(1'b1, 10);
    @(posedge ref_clk);
    volt <= 12'h5dc;
    expect_contact(1'b0, 20);
    $display("test charge voltage done");
  endtask : t_socv

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    fails++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_charge();
    t_quiet();
    t_generic();
    t_exercise();
    t_manual();
    t_socv();
    give_verdict();
  end
endmodule : generator_run_control_tb
`default_nettype wire
